// [include/pba_map.svh]
// register offsets, field positions, reset values and timing counts of the
// processor bus arbiter; included by the arbiter module and the testbench
`ifndef PBA_MAP_SVH
`define PBA_MAP_SVH
// ==========================================
// offsets (byte addresses, one word each)
`define PBA_OFS_ARB_CTRL  12'h000
`define PBA_OFS_RESET_CS  12'h004
`define PBA_OFS_MISC_CS   12'h008
// ==========================================
// field positions
`define PBA_F_EN_LSB      0
`define PBA_F_PRI_LSB     3
`define PBA_F_PARK_BIT    7
`define PBA_F_SEL_LSB     8
`define PBA_F_DLY_BIT     10
`define PBA_F_ARBON_BIT   11
`define PBA_F_OWNER_LSB   12
`define PBA_F_BOOT_BIT    0
`define PBA_F_QUAL_BIT    1
`define PBA_F_LOCK_LSB    0
// ==========================================
// reset values
`define PBA_RST_EN_PB     3'h1
`define PBA_RST_EN_PCI    3'h0
`define PBA_RST_LOCK_PB   2'h3
`define PBA_RST_LOCK_PCI  2'h0
`define PBA_RST_PRI       4'h0
`define PBA_RST_PARK      1'b1
`define PBA_RST_SEL       2'h0
// ==========================================
// timing: edges after reset release before straps are taken
`define PBA_STRAP_WAIT    2'h2
`endif

// [include/pba_pkg.sv]
// types shared by the processor bus arbiter files
// assumes pba_map.svh sits on the include path
package pba_pkg;
  typedef struct packed {
    logic       dly;
    logic [1:0] park_sel;
    logic       park_last;
    logic [3:0] pri;
    logic [2:0] en;
  } pba_arb_ctrl_t;

  // synchronised processor bus pins, active high
  typedef struct packed {
    logic ts;
    logic tt;
    logic aack;
    logic dbb;
  } pba_bus_in_t;

  typedef enum logic [1:0] {
    DG_IDLE  = 2'b00,
    DG_DELAY = 2'b01,
    DG_PEND  = 2'b11,
    DG_GRANT = 2'b10
  } pba_dg_state_t;
endpackage

// [src/pba_sync.sv]
// two flip-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
module pba_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // rst_val is a tie-off constant at every instance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d ^ rst_val;
      q        <= meta_reg;
    end
  end
endmodule

// [src/pba_rr.sv]
// round-robin picker: first request after the last one taken
// assumes adv is only raised while some request is present
`timescale 1ns/1ps
module pba_rr #(
  parameter int N = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [N-1:0]         req,
  input  wire logic                 adv,
  output logic      [$clog2(N)-1:0] pick
);
  logic [$clog2(N)-1:0] last_reg;
  logic [$clog2(N)-1:0] idx;

  always_comb begin
    pick = last_reg;
    for (int k = N; k >= 1; k--) begin
      idx = $clog2(N)'((int'(last_reg) + k) % N);
      if (req[idx]) begin
        pick = idx;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= '0;
    end else if (adv) begin
      last_reg <= pick;
    end
  end
endmodule

// [src/pba_arbiter.sv]
// processor bus arbiter with APB register slave
// assumes APB master on pclk; bus pins are asynchronous and synchronised here
// Summary of operation
// - strap enables arbiter; else use line 1
// - serve own master plus three external masters
// - disabled external masters are ignored
// - two priority levels, round robin each
// - grant moves on idle request or acknowledge
// - park on last or selected master
// - type bit at start requests data bus
// - data grant one clock, or two delayed
// - negate data grant once master qualifies
// - qualify mode holds grant while bus busy
// - type bit low means address only
// - PCI boot: flag set, enables cleared
// - bus boot: flag clear, master 1 enabled
// - PCI boot clears both lockout bits
// - lockout bit retries configuration cycles
// - boot strap applies with arbiter disabled too
`timescale 1ns/1ps
`include "pba_map.svh"
module pba_arbiter
  import pba_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_arbiter_strap,
  input  wire logic        boot_source_strap,
  input  wire logic        grant_qualify_strap,
  input  wire logic [3:1]  addr_bus_request_n,
  output logic      [3:1]  addr_bus_grant_n,
  output logic      [3:1]  data_bus_grant_n,
  input  wire logic        transfer_start_n,
  input  wire logic        transfer_type_bit,
  input  wire logic        addr_acknowledge_n,
  input  wire logic        data_bus_busy_n,
  input  wire logic        int_addr_request,
  input  wire logic        int_data_busy,
  output logic             int_addr_grant,
  output logic             int_data_grant,
  output logic             own_request_n,
  input  wire logic        own_addr_grant_n,
  input  wire logic        own_data_grant_n,
  input  wire logic [1:0]  eeprom_lockout_clear,
  output logic      [1:0]  config_lockout
);
  // ==========================================
  // pin synchronisers (active-low pins inverted on the way in)
  logic [11:0]   sync_q;
  logic          arb_strap_s;
  logic          boot_strap_s;
  logic          qual_strap_s;
  logic [3:1]    req_s;
  logic          own_ag_s;
  logic          own_dg_s;
  pba_bus_in_t   bus_s;

  pba_sync #(.W(12)) u_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .d       ({host_arbiter_strap, boot_source_strap, grant_qualify_strap,
               addr_bus_request_n, transfer_start_n, transfer_type_bit,
               addr_acknowledge_n, data_bus_busy_n,
               own_addr_grant_n, own_data_grant_n}),
    .rst_val (12'h1ef),
    .q       (sync_q)
  );
  assign {arb_strap_s, boot_strap_s, qual_strap_s, req_s} = sync_q[11:6];
  assign bus_s    = sync_q[5:2];
  assign own_ag_s = sync_q[1];
  assign own_dg_s = sync_q[0];

  // ==========================================
  // strap capture after reset release
  logic [1:0] strap_cnt_reg;
  logic       straps_done_reg;
  logic       load_go;

  assign load_go = !straps_done_reg && (strap_cnt_reg == `PBA_STRAP_WAIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg   <= 2'h0;
      straps_done_reg <= 1'b0;
    end else if (!straps_done_reg) begin
      strap_cnt_reg   <= strap_cnt_reg + 2'h1;
      straps_done_reg <= load_go;
    end
  end

  // ==========================================
  // APB slave: one wait state so read data leave a flop
  pba_arb_ctrl_t ctrl_reg;
  logic          arb_on_reg;
  logic          boot_pci_reg;
  logic          qual_mode_reg;
  logic [1:0]    lock_reg;
  logic [1:0]    owner_reg;
  logic          acc;
  logic          fire;
  logic          hit_ctrl;
  logic          hit_reset;
  logic          hit_misc;
  logic [31:0]   rdata;

  assign acc       = psel && penable;
  assign fire      = acc && pready;
  assign hit_ctrl  = (paddr == `PBA_OFS_ARB_CTRL);
  assign hit_reset = (paddr == `PBA_OFS_RESET_CS);
  assign hit_misc  = (paddr == `PBA_OFS_MISC_CS);

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata[`PBA_F_SEL_LSB +: 3]    = {ctrl_reg.dly, ctrl_reg.park_sel};
      rdata[`PBA_F_PARK_BIT]        = ctrl_reg.park_last;
      rdata[`PBA_F_PRI_LSB +: 4]    = ctrl_reg.pri;
      rdata[`PBA_F_EN_LSB +: 3]     = ctrl_reg.en;
      rdata[`PBA_F_ARBON_BIT]       = arb_on_reg;
      rdata[`PBA_F_OWNER_LSB +: 2]  = owner_reg;
    end else if (hit_reset) begin
      rdata[`PBA_F_BOOT_BIT] = boot_pci_reg;
      rdata[`PBA_F_QUAL_BIT] = qual_mode_reg;
    end else if (hit_misc) begin
      rdata[`PBA_F_LOCK_LSB +: 2] = lock_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !(hit_ctrl || hit_reset || hit_misc);
      if (acc && !pready && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '{dly: 1'b0, park_sel: `PBA_RST_SEL, park_last: `PBA_RST_PARK,
                    pri: `PBA_RST_PRI, en: `PBA_RST_EN_PCI};
    end else if (load_go) begin
      // boot choice sets enables whether or not the arbiter is on
      ctrl_reg.en <= boot_strap_s ? `PBA_RST_EN_PCI : `PBA_RST_EN_PB;
    end else if (fire && pwrite && hit_ctrl) begin
      ctrl_reg.en        <= pwdata[`PBA_F_EN_LSB +: 3];
      ctrl_reg.pri       <= pwdata[`PBA_F_PRI_LSB +: 4];
      ctrl_reg.park_last <= pwdata[`PBA_F_PARK_BIT];
      ctrl_reg.park_sel  <= pwdata[`PBA_F_SEL_LSB +: 2];
      ctrl_reg.dly       <= pwdata[`PBA_F_DLY_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_on_reg    <= 1'b0;
      boot_pci_reg  <= 1'b0;
      qual_mode_reg <= 1'b0;
    end else if (load_go) begin
      arb_on_reg    <= arb_strap_s;
      boot_pci_reg  <= boot_strap_s;
      qual_mode_reg <= qual_strap_s;
    end else if (fire && pwrite && hit_reset) begin
      qual_mode_reg <= pwdata[`PBA_F_QUAL_BIT];
    end
  end

  // lockout held set through reset so no config cycle slips in early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= `PBA_RST_LOCK_PB;
    end else if (load_go) begin
      lock_reg <= boot_strap_s ? `PBA_RST_LOCK_PCI : `PBA_RST_LOCK_PB;
    end else begin
      if (fire && pwrite && hit_misc) begin
        lock_reg <= pwdata[`PBA_F_LOCK_LSB +: 2];
      end
      if (eeprom_lockout_clear[0]) begin
        lock_reg[0] <= 1'b0;
      end
      if (eeprom_lockout_clear[1]) begin
        lock_reg[1] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_lockout <= `PBA_RST_LOCK_PB;
    end else begin
      config_lockout <= lock_reg;
    end
  end

  // ==========================================
  // address bus arbitration
  logic [3:0] req_v;
  logic [3:0] hi_req;
  logic [3:0] lo_req;
  logic [1:0] hi_pick;
  logic [1:0] lo_pick;
  logic [1:0] winner;
  logic [1:0] park_tgt;
  logic       choose_lo;
  logic       addr_busy_reg;
  logic       low_turn_reg;
  logic       running;
  logic       update;

  assign running   = arb_on_reg && straps_done_reg;
  assign req_v     = {req_s & ctrl_reg.en, int_addr_request};
  assign hi_req    = req_v & ctrl_reg.pri;
  assign lo_req    = req_v & ~ctrl_reg.pri;
  // low group takes the turn after a high-group grant made while a low request waits
  assign choose_lo = (|lo_req) && (!(|hi_req) || low_turn_reg);
  assign winner    = choose_lo ? lo_pick : hi_pick;
  assign park_tgt  = ctrl_reg.park_last ? owner_reg : ctrl_reg.park_sel;
  assign update    = running && (bus_s.aack ||
                     (!addr_busy_reg && (|req_v) && !req_v[owner_reg]));

  pba_rr #(.N(4)) u_rr_hi (
    .clk   (pclk),
    .rst_n (presetn),
    .req   (hi_req),
    .adv   (update && (|req_v) && !choose_lo),
    .pick  (hi_pick)
  );

  pba_rr #(.N(4)) u_rr_lo (
    .clk   (pclk),
    .rst_n (presetn),
    .req   (lo_req),
    .adv   (update && choose_lo),
    .pick  (lo_pick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner_reg    <= `PBA_RST_SEL;
      low_turn_reg <= 1'b0;
    end else if (load_go) begin
      owner_reg <= ctrl_reg.park_sel;
    end else if (update) begin
      owner_reg    <= (|req_v) ? winner : park_tgt;
      low_turn_reg <= (|req_v) && !choose_lo && (|lo_req);
    end
  end

  // address tenure runs from transfer start to acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_busy_reg <= 1'b0;
    end else if (bus_s.aack) begin
      addr_busy_reg <= 1'b0;
    end else if (bus_s.ts) begin
      addr_busy_reg <= 1'b1;
    end
  end

  // grants are unqualified; masters check bus busy before driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_bus_grant_n <= 3'h7;
      int_addr_grant   <= 1'b0;
      own_request_n    <= 1'b1;
    end else begin
      for (int i = 1; i <= 3; i++) begin
        addr_bus_grant_n[i] <= !(running && owner_reg == 2'(i));
      end
      int_addr_grant <= arb_on_reg ? (running && owner_reg == 2'h0) : own_ag_s;
      own_request_n  <= arb_on_reg || !int_addr_request;
    end
  end

  // ==========================================
  // data bus arbitration
  pba_dg_state_t dg_state_reg;
  pba_dg_state_t dg_next;
  logic [1:0]    dmaster_reg;
  logic          dbb_d_reg;
  logic          ibusy_d_reg;
  logic          qual_ok;
  logic          started;
  logic [1:0]    dgrant_tgt;

  assign qual_ok = !qual_mode_reg || !(bus_s.dbb || int_data_busy);
  assign started = (dmaster_reg == 2'h0) ? (int_data_busy && !ibusy_d_reg)
                                         : (bus_s.dbb && !dbb_d_reg);
  // direct grant leaves idle before the master latch has caught the owner
  assign dgrant_tgt = (dg_state_reg == DG_IDLE) ? owner_reg : dmaster_reg;

  always_comb begin
    dg_next = dg_state_reg;
    unique case (dg_state_reg)
      DG_IDLE: begin
        // type bit only counts in the start cycle; it is stale a clock later
        if (running && bus_s.ts && bus_s.tt) begin
          if (ctrl_reg.dly) begin
            dg_next = DG_DELAY;
          end else begin
            dg_next = qual_ok ? DG_GRANT : DG_PEND;
          end
        end
      end
      DG_DELAY: begin
        dg_next = qual_ok ? DG_GRANT : DG_PEND;
      end
      DG_PEND: begin
        if (qual_ok) begin
          dg_next = DG_GRANT;
        end
      end
      DG_GRANT: begin
        if (started) begin
          dg_next = DG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dg_state_reg <= DG_IDLE;
      dmaster_reg  <= 2'h0;
      dbb_d_reg    <= 1'b0;
      ibusy_d_reg  <= 1'b0;
    end else begin
      dg_state_reg <= dg_next;
      dbb_d_reg    <= bus_s.dbb;
      ibusy_d_reg  <= int_data_busy;
      if (dg_state_reg == DG_IDLE && bus_s.ts) begin
        dmaster_reg <= owner_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_bus_grant_n <= 3'h7;
      int_data_grant   <= 1'b0;
    end else begin
      for (int i = 1; i <= 3; i++) begin
        data_bus_grant_n[i] <= !(dg_next == DG_GRANT && dgrant_tgt == 2'(i));
      end
      int_data_grant <= arb_on_reg ? (dg_next == DG_GRANT && dgrant_tgt == 2'h0)
                                   : own_dg_s;
    end
  end

  // ==========================================
  // checks
  winner_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update && (|req_v)) |-> req_v[winner])
    else $error("grant given to a master that is not requesting");
  grant_move_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(straps_done_reg) && owner_reg != $past(owner_reg)) |-> $past(update))
    else $error("address owner moved without idle request or acknowledge");
  park_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update && !(|req_v) && !ctrl_reg.park_last) |=> owner_reg == $past(ctrl_reg.park_sel))
    else $error("bus not parked on selected master");
  park_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update && !(|req_v) && ctrl_reg.park_last) |=> $stable(owner_reg))
    else $error("bus not parked on last master");
  addr_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dg_state_reg == DG_IDLE && running && bus_s.ts && !bus_s.tt)
    |=> ##1 (data_bus_grant_n == 3'h7 && !int_data_grant))
    else $error("data bus granted on address only cycle");
  dgrant_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dg_state_reg == DG_IDLE && running && bus_s.ts && !ctrl_reg.dly && bus_s.tt && qual_ok)
    |=> ((data_bus_grant_n != 3'h7) || int_data_grant))
    else $error("data grant not one clock after start");
  dgrant_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dg_state_reg == DG_IDLE && running && bus_s.ts && bus_s.tt && ctrl_reg.dly)
    |=> (data_bus_grant_n == 3'h7 && !int_data_grant && dg_state_reg == DG_DELAY))
    else $error("delayed sample granted early");
  qual_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dg_state_reg == DG_PEND && !qual_ok) |=> dg_state_reg == DG_PEND)
    else $error("data grant issued while bus busy in qualify mode");
  dgrant_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dg_state_reg == DG_GRANT && started) |=> (data_bus_grant_n == 3'h7 && !int_data_grant))
    else $error("data grant kept after qualification");
  boot_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_go |=> ##1 (config_lockout == (boot_pci_reg ? `PBA_RST_LOCK_PCI : `PBA_RST_LOCK_PB)
                 && ctrl_reg.en == (boot_pci_reg ? `PBA_RST_EN_PCI : `PBA_RST_EN_PB)))
    else $error("boot strap defaults not applied");
  own_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!arb_on_reg && int_addr_request) |=> !own_request_n)
    else $error("own request not driven to external arbiter");
endmodule

// [bench/pba_bus_model.sv]
// external processor bus masters 1..3 facing the arbiter
// assumes active-low grants sampled on rising clk; released lines pull high
`timescale 1ns/1ps
module pba_bus_model (
  input  wire logic       clk,
  input  wire logic [3:1] abg_n,
  input  wire logic [3:1] dbg_n,
  output logic      [3:1] req_n,
  output logic            ts_n,
  output logic            tt,
  output logic            aack_n,
  output logic            dbb_n
);
  initial begin
    req_n = 3'h7;
    ts_n = 1'b1;
    tt = 1'b0;
    aack_n = 1'b1;
    dbb_n = 1'b1;
  end

  task automatic ask(input int m, input logic v);
    req_n[m] <= v;
  endtask

  // =========================
  // one address tenure; lat = edges from start to data grant, 99 if none
  task automatic tenure(input int m, input logic t, output int lat);
    int n;
    @(posedge clk);
    req_n[m] <= 1'b0;
    // no address drive before own request and address grant; bus busy is not checked
    do begin
      @(posedge clk);
    end while (abg_n[m] !== 1'b0);
    // request dropped with start so the arbiter can park at acknowledge
    ts_n <= 1'b0;
    tt <= t;
    req_n[m] <= 1'b1;
    lat = 99;
    for (n = 1; n < 16; n++) begin
      @(posedge clk);
      if (dbg_n[m] === 1'b0 && lat == 99)
        lat = n;
      ts_n <= 1'b1;
      tt <= ~t;
      aack_n <= (n != 1);
      dbb_n <= !(lat != 99 && n < lat + 3); // master qualifies its grant
    end
  endtask
endmodule

// [bench/tb_processor_bus_arbiter.sv]
// self-checking bench of the processor bus arbiter
// assumes pba_map.svh on the include path and one-wait-state APB slave
`timescale 1ns/1ps
`include "pba_map.svh"
module tb_processor_bus_arbiter;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic        host_arbiter_strap, boot_source_strap, grant_qualify_strap;
  logic [3:1]  abg_n, dbg_n, req_n;
  logic        ts_n, tt, aack_n, dbb_n, int_req, own_req_n;
  logic        int_ag, int_dg, own_ag_n, own_dg_n, ibusy;
  logic [1:0]  ee_clr, lock;
  logic [64:0] ent;
  logic [64:0] expq[$];
  int          fails, tests_run, seed, lat0, lat;

  pba_arbiter dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .host_arbiter_strap, .boot_source_strap, .grant_qualify_strap,
    .addr_bus_request_n(req_n), .addr_bus_grant_n(abg_n), .data_bus_grant_n(dbg_n),
    .transfer_start_n(ts_n), .transfer_type_bit(tt), .addr_acknowledge_n(aack_n),
    .data_bus_busy_n(dbb_n), .int_addr_request(int_req), .int_data_busy(ibusy),
    .int_addr_grant(int_ag), .int_data_grant(int_dg), .own_request_n(own_req_n),
    .own_addr_grant_n(own_ag_n), .own_data_grant_n(own_dg_n), .eeprom_lockout_clear(ee_clr),
    .config_lockout(lock));
  pba_bus_model bfm (.clk(pclk), .abg_n, .dbg_n, .req_n, .ts_n, .tt, .aack_n, .dbb_n);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // =========================
  // checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // read notes carry {error, mask, data}; writes compare only the error bit
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      ent = expq.pop_front();
      chk(prdata & ent[63:32], ent[31:0] & ent[63:32]);
      chk({31'h0, pslverr}, {31'h0, ent[64]});
    end
  end

  // =========================
  // drivers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    expq.push_back({e, m, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic boot(input logic pci, input logic arb);
    presetn <= 1'b0;
    boot_source_strap <= pci;
    host_arbiter_strap <= arb;
    grant_qualify_strap <= pci;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    results();
  end

  // =========================
  // scenarios
  initial begin
    seed = 32'hea15ca57;
    fails = 0;
    tests_run = 0;
    {psel, penable, pwrite, paddr, pwdata, int_req, ee_clr, ibusy} = '0;
    {own_ag_n, own_dg_n} = 2'b11;
    presetn = 1'b0;
    {host_arbiter_strap, boot_source_strap, grant_qualify_strap} = 3'b100;
    boot(1'b0, 1'b1);
    chk({30'h0, lock}, 32'h0000_0003);
    chk({31'h0, int_ag}, 32'h0000_0001);
    apb(0, `PBA_OFS_ARB_CTRL, 32'h0000_0881, 32'h0000_0fff, 0);
    apb(0, `PBA_OFS_RESET_CS, 32'h0000_0000, 32'h0000_0003, 0);
    apb(0, 12'h0fc, 32'h0000_0000, 32'hffff_ffff, 1);
    apb(1, `PBA_OFS_MISC_CS, 32'h0000_0001, 32'h0000_0000, 0);
    apb(0, `PBA_OFS_MISC_CS, 32'h0000_0001, 32'h0000_0003, 0);
    chk({30'h0, lock}, 32'h0000_0001);
    ee_clr <= 2'b01;
    @(posedge pclk);
    ee_clr <= 2'b00;
    repeat (3) @(posedge pclk);
    chk({30'h0, lock}, 32'h0000_0000);
    bfm.ask(2, 1'b0);
    repeat (12) @(posedge pclk);
    chk({31'h0, abg_n[2]}, 32'h0000_0001);
    bfm.ask(2, 1'b1);
    bfm.tenure(1, 1'b1, lat0);
    chk({29'h0, dbg_n}, 32'h0000_0007);
    chk({31'h0, lat0 == 99}, 32'h0000_0000);
    bfm.tenure(1, 1'b0, lat);
    chk(lat, 99);
    // qualify mode: own data tenure busy holds the grant until it ends
    apb(1, `PBA_OFS_RESET_CS, 32'h0000_0002, 32'h0000_0000, 0);
    ibusy <= 1'b1;
    fork
      bfm.tenure(1, 1'b1, lat);
      begin
        repeat (6) @(posedge pclk);
        ibusy <= 1'b0;
      end
    join
    chk(lat, lat0 + 2);
    apb(1, `PBA_OFS_RESET_CS, 32'h0000_0000, 32'h0000_0000, 0);
    apb(1, `PBA_OFS_ARB_CTRL, 32'h0000_0481, 32'h0000_0000, 0);
    bfm.tenure(1, 1'b1, lat);
    chk(lat, lat0 + 1);
    apb(1, `PBA_OFS_ARB_CTRL, 32'h0000_0023, 32'h0000_0000, 0);
    bfm.tenure(1, 1'b1, lat);
    chk({29'h0, abg_n}, 32'h0000_0007);
    bfm.ask(1, 1'b0);
    bfm.ask(2, 1'b0);
    repeat (8) @(posedge pclk);
    chk({29'h0, abg_n}, 32'h0000_0005);
    bfm.ask(1, 1'b1);
    bfm.ask(2, 1'b1);
    v = 32'h0000_0203 | ($random(seed) & 32'h0000_0078);
    apb(1, `PBA_OFS_ARB_CTRL, v, 32'h0000_0000, 0);
    repeat (10) @(posedge pclk);
    chk({29'h0, abg_n}, 32'h0000_0005);
    apb(0, `PBA_OFS_ARB_CTRL, v | 32'h0000_2800, 32'h0000_3fff, 0);
    bfm.tenure(2, 1'b1, lat);
    chk({31'h0, lat == 99}, 32'h0000_0000);
    apb(1, `PBA_OFS_ARB_CTRL, 32'h0000_0083, 32'h0000_0000, 0);
    bfm.tenure(1, 1'b1, lat);
    repeat (10) @(posedge pclk);
    chk({29'h0, abg_n}, 32'h0000_0006);
    boot(1'b1, 1'b0);
    chk({30'h0, lock}, 32'h0000_0000);
    apb(0, `PBA_OFS_ARB_CTRL, 32'h0000_0080, 32'h0000_0fff, 0);
    apb(0, `PBA_OFS_RESET_CS, 32'h0000_0003, 32'h0000_0003, 0);
    int_req <= 1'b1;
    own_ag_n <= 1'b0;
    own_dg_n <= 1'b0;
    bfm.ask(1, 1'b0);
    repeat (10) @(posedge pclk);
    chk({31'h0, own_req_n}, 32'h0000_0000);
    chk({29'h0, abg_n}, 32'h0000_0007);
    chk({31'h0, int_ag}, 32'h0000_0001);
    chk({31'h0, int_dg}, 32'h0000_0001);
    results();
  end
endmodule
